// >>> core/rxeq_params.svh
// Constants for the receiver equalizer adaptation control block.
`ifndef RXEQ_PARAMS_SVH
`define RXEQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define RXEQ_CLK_MHZ            20
`define RXEQ_ADAPT_DONE_TIME_US 5000
`define RXEQ_DWELL_TIME_NS      3200

// ----------------------------------------------------------------------------
// equalizer settings and fields
// ----------------------------------------------------------------------------
`define RXEQ_EQ_W          4
`define RXEQ_EQ_MIN        4'h0
`define RXEQ_EQ_MAX        4'hF
`define RXEQ_EQ_BYPASS     4'h0
`define RXEQ_DCG_BYPASS    2'h2
`define RXEQ_LANES         4
`define RXEQ_CLK_LANE      3
`define RXEQ_LANES_ALL     4'hF
`define RXEQ_LANES_THREE   4'h7
`define RXEQ_LANES_NONE    4'h0

// ----------------------------------------------------------------------------
// training patterns and emphasis levels
// ----------------------------------------------------------------------------
`define RXEQ_LTP_TEST_LO   4'h1
`define RXEQ_LTP_TEST_HI   4'h4
`define RXEQ_LTP_ADAPT_LO  4'h5
`define RXEQ_LTP_ADAPT_HI  4'h8
`define RXEQ_TXFFE0        2'h0
`define RXEQ_TXFFE1        2'h1
`define RXEQ_TXFFE2        2'h2
`define RXEQ_TXFFE3        2'h3

`endif

// >>> core/rxeq_pkg.sv
// Types shared by the receiver equalizer adaptation control block.
package rxeq_pkg;

  // four-level strap pin reading
  typedef enum logic [1:0] {
    LVL_0,
    LVL_R,
    LVL_F,
    LVL_1
  } rxeq_level_t;

  // link mode reported by the control-channel snooper
  typedef enum logic [1:0] {
    LINK_LEGACY14,
    LINK_LEGACY20,
    LINK_FRL,
    LINK_UNUSED
  } rxeq_link_t;

  // adaptation sequencer
  typedef enum logic [1:0] {
    ADAPT_IDLE,
    ADAPT_SCAN,
    ADAPT_DONE
  } rxeq_adapt_state_t;

endpackage

// >>> core/rxeq_txffe_reduce.sv
// Equalizer reduction for one lane per requested emphasis level.
`timescale 1ns/1ps
`include "rxeq_params.svh"
module rxeq_txffe_reduce (
  // control
  input  wire logic       enable,
  input  wire logic [1:0] level,
  // settings
  input  wire logic [3:0] initEq,
  output logic      [3:0] reducedEq
);

  wire logic [3:0] ffe1Eq;
  wire logic [3:0] ffe2Eq;
  wire logic [3:0] ffe3Eq;

  assign ffe1Eq = (initEq < 4'h8) ? (initEq >> 1) : (initEq - 4'h4); // (R20)
  assign ffe2Eq = (initEq < 4'h4) ? 4'h0 :
                  (initEq < 4'h8) ? 4'h1 : (initEq - 4'h6); // (R21)
  assign ffe3Eq = (initEq < 4'h8) ? 4'h0 :
                  (initEq < 4'hC) ? 4'h1 : (initEq - 4'hA); // (R22)

  // without the compatible mode every level keeps the initial setting
  assign reducedEq = (!enable || level == `RXEQ_TXFFE0) ? initEq :
                     (level == `RXEQ_TXFFE1) ? ffe1Eq :
                     (level == `RXEQ_TXFFE2) ? ffe2Eq : ffe3Eq;

endmodule

// >>> core/rxeq_adapt_control.sv
// Receiver equalizer selection: bypass, adaptation and emphasis-level reduction.
//
// Operation
// (R1) Register mode: buffer behaviour only when bypass enable is 1 and DC gain is 2.
// (R2) Bypass never available when configured by strap pins.
// (R3) With bypass on, lanes at setting 0 skip the equalizer; others stay equalized.
// (R4) Adapt only in fixed-rate mode; legacy modes use strap or register setting; the clock lane runs at the lowest setting instead.
// (R5) Register mode adapts only when the adapt enable bit is set.
// (R6) Scan settings upward, keep the highest one that is not over-equalized.
// (R7) Start adaptation when training begins; restart on every data rate change.
// (R8) Step only during emphasis level 0 while patterns 5 to 8 arrive.
// (R9) Adaptation ends within a fixed time counted from training start.
// (R10) Levels 1 to 3 hold the setting found at level 0; no re-adaptation.
// (R11) After fallback to legacy use strap setting, or register setting in register mode; the clock lane runs at the lowest setting instead.
// (R12) Lane outputs off until adaptation completes, then lanes for the mode on.
// (R13) Register mode: clearing the hold bit removes the output hold.
// (R14) Strap enable: mode 0 off; R and 1 on for map F and 1; F uses register.
// (R15) Observe lane 0 only; apply the result to every fixed-rate data lane.
// (R16) Test patterns 1 to 4 before training use the strap setting.
// (R17) Emphasis-compatible reduction only when configured as a limited redriver.
// (R18) Reduction allowed in register mode and every strap mode but mode 0.
// (R19) Level 0 initial setting: straps without adaptation, adapted value with it; register mode uses the register setting instead of straps.
// (R20) Level 1: half of initial for 0 to 7, initial minus four for 8 to 15.
// (R21) Level 2: 0 for 0 to 3, 1 for 4 to 7, minus six for 8 to 15.
// (R22) Level 3: 0 for 0 to 7, 1 for 8 to 11, minus ten for 12 to 15.
// (R23) Strap setting is row times four plus column from the two four-level pins.
// (R24) Training stage, emphasis level, pattern and rate come from a snooping unit.
`timescale 1ns/1ps
`include "rxeq_params.svh"
module rxeq_adapt_control #(
  parameter int unsigned ADAPT_DONE_CYCLES = `RXEQ_ADAPT_DONE_TIME_US * `RXEQ_CLK_MHZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // strap pins, four-level readings coded 0,R,F,1
  input  wire logic [1:0] modeStrap,
  input  wire logic [1:0] eqMapSelectStrap,
  input  wire logic [3:0] eqStrapPins,
  // configuration bits
  input  wire logic       limitedRedriver,
  input  wire logic       eqBypassEnable,
  input  wire logic [1:0] globalDcGain,
  input  wire logic       adaptEnable,
  input  wire logic       outputHoldUntilAdapted,
  input  wire logic [3:0] regEqLane0,
  input  wire logic [3:0] regEqLane1,
  input  wire logic [3:0] regEqLane2,
  input  wire logic [3:0] regEqLane3,
  // snooped link state
  input  wire logic [1:0] linkMode,
  input  wire logic       trainActive,
  input  wire logic [1:0] txffeLevel,
  input  wire logic [3:0] patternNum,
  input  wire logic [2:0] dataRate,
  input  wire logic       frlFourLane,
  // lane 0 front-end detector
  input  wire logic       dataLane0OverEq,
  // equalizer and lane controls
  output logic      [3:0] laneEq0,
  output logic      [3:0] laneEq1,
  output logic      [3:0] laneEq2,
  output logic      [3:0] laneEq3,
  output logic      [3:0] laneBypass,
  output logic      [3:0] laneOutEnable,
  // adaptation status
  output logic            adaptDone,
  output logic      [3:0] adaptedEq
);

  localparam int unsigned DWELL_CYCLES = (`RXEQ_DWELL_TIME_NS * `RXEQ_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------------
  // synchronisers and strap capture
  // ----------------------------------------------------------------------------
  logic [8:0] pinMeta_r;
  logic [8:0] pinSync_r;
  logic [1:0] strapCnt_r;
  rxeq_pkg::rxeq_level_t strapMode_r;
  rxeq_pkg::rxeq_level_t strapMap_r;
  rxeq_pkg::rxeq_level_t strapUpper_r;
  rxeq_pkg::rxeq_level_t strapLower_r;

  wire logic strapTake;
  wire logic strapValid;
  wire logic overEq;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_r <= 9'h000;
      pinSync_r <= 9'h000;
    end else begin
      pinMeta_r <= {dataLane0OverEq, modeStrap, eqMapSelectStrap, eqStrapPins};
      pinSync_r <= pinMeta_r;
    end
  end

  // straps are latched once, after the synchroniser has settled
  assign strapTake  = (strapCnt_r == 2'h2);
  assign strapValid = (strapCnt_r == 2'h3);
  assign overEq     = pinSync_r[8];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapCnt_r   <= 2'h0;
      strapMode_r  <= rxeq_pkg::LVL_0;
      strapMap_r   <= rxeq_pkg::LVL_0;
      strapUpper_r <= rxeq_pkg::LVL_0;
      strapLower_r <= rxeq_pkg::LVL_0;
    end else begin
      if (!strapValid) strapCnt_r <= strapCnt_r + 2'h1;
      if (strapTake) begin
        strapMode_r  <= rxeq_pkg::rxeq_level_t'(pinSync_r[7:6]);
        strapMap_r   <= rxeq_pkg::rxeq_level_t'(pinSync_r[5:4]);
        strapUpper_r <= rxeq_pkg::rxeq_level_t'(pinSync_r[3:2]);
        strapLower_r <= rxeq_pkg::rxeq_level_t'(pinSync_r[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------------------
  wire logic       regMode;
  wire logic [1:0] strapRow;
  wire logic [1:0] strapCol;
  wire logic [3:0] strapEq;
  wire logic       mapAdaptOk;
  wire logic       adaptEnabled;
  wire logic       isFrl;
  wire logic       adaptOn;
  wire logic       bypassOn;
  wire logic       compatOn;
  wire logic       ltpAdapt;
  wire logic       ltpTest;

  // the mode strap at level F hands control to the register bits
  assign regMode  = (strapMode_r == rxeq_pkg::LVL_F);
  assign strapRow = (strapUpper_r == rxeq_pkg::LVL_0) ? 2'h0 :
                    (strapUpper_r == rxeq_pkg::LVL_F) ? 2'h1 :
                    (strapUpper_r == rxeq_pkg::LVL_R) ? 2'h2 : 2'h3; // (R23)
  assign strapCol = strapLower_r; // (R23)
  assign strapEq  = {strapRow, strapCol}; // (R23)

  assign mapAdaptOk   = (strapMap_r == rxeq_pkg::LVL_F) || (strapMap_r == rxeq_pkg::LVL_1);
  assign adaptEnabled = regMode ? adaptEnable : // (R5)
                        ((strapMode_r == rxeq_pkg::LVL_R) || (strapMode_r == rxeq_pkg::LVL_1)) &&
                        mapAdaptOk; // (R14)
  assign isFrl    = (linkMode == rxeq_pkg::LINK_FRL); // (R24)
  assign adaptOn  = isFrl && adaptEnabled && strapValid; // (R4)
  assign bypassOn = regMode && eqBypassEnable && (globalDcGain == `RXEQ_DCG_BYPASS); // (R1) (R2)
  assign compatOn = limitedRedriver && (regMode || strapMode_r != rxeq_pkg::LVL_0); // (R17) (R18)
  assign ltpAdapt = (patternNum >= `RXEQ_LTP_ADAPT_LO) && (patternNum <= `RXEQ_LTP_ADAPT_HI);
  assign ltpTest  = (patternNum >= `RXEQ_LTP_TEST_LO) && (patternNum <= `RXEQ_LTP_TEST_HI);

  // ----------------------------------------------------------------------------
  // adaptation sequencer
  // ----------------------------------------------------------------------------
  rxeq_pkg::rxeq_adapt_state_t state_r;
  rxeq_pkg::rxeq_adapt_state_t state_nxt;
  logic [23:0] timer_r;
  logic [23:0] timer_nxt;
  logic [7:0]  dwell_r;
  logic [7:0]  dwell_nxt;
  logic [3:0]  setting_r;
  logic [3:0]  setting_nxt;
  logic [3:0]  best_r;
  logic [3:0]  best_nxt;
  logic        trainActive_r;
  logic [2:0]  rate_r;
  logic        trained_r;

  wire logic trainRise;
  wire logic rateChange;
  wire logic startAdapt;
  wire logic stepOk;
  wire logic timerEnd;
  wire logic dwellEnd;

  assign trainRise  = trainActive && !trainActive_r && isFrl;
  assign rateChange = isFrl && trainActive && (dataRate != rate_r);
  assign startAdapt = adaptOn && (trainRise || rateChange); // (R7)
  assign stepOk     = (txffeLevel == `RXEQ_TXFFE0) && ltpAdapt; // (R8)
  assign timerEnd   = (timer_r >= 24'(ADAPT_DONE_CYCLES - 1)); // (R9)
  assign dwellEnd   = (dwell_r == 8'(DWELL_CYCLES - 1));

  always_comb begin
    state_nxt   = state_r;
    timer_nxt   = timer_r;
    dwell_nxt   = dwell_r;
    setting_nxt = setting_r;
    best_nxt    = best_r;
    case (state_r)
      rxeq_pkg::ADAPT_SCAN: begin
        timer_nxt = timer_r + 24'h000001;
        if (timerEnd) begin
          state_nxt = rxeq_pkg::ADAPT_DONE; // (R9)
        end else if (stepOk) begin
          dwell_nxt = dwell_r + 8'h01;
          if (dwellEnd) begin
            dwell_nxt = 8'h00;
            // the first over-equalized step ends the scan; best keeps the last clean one
            if (overEq) begin
              state_nxt = rxeq_pkg::ADAPT_DONE; // (R6)
            end else begin
              best_nxt = setting_r; // (R6)
              if (setting_r == `RXEQ_EQ_MAX) begin
                state_nxt = rxeq_pkg::ADAPT_DONE;
              end else begin
                setting_nxt = setting_r + 4'h1; // (R6)
              end
            end
          end
        end
      end
      default: begin
      end
    endcase
    if (!adaptOn) begin
      state_nxt = rxeq_pkg::ADAPT_IDLE; // (R4) (R5)
    end
    if (startAdapt) begin
      state_nxt   = rxeq_pkg::ADAPT_SCAN; // (R7)
      timer_nxt   = 24'h000000;
      dwell_nxt   = 8'h00;
      setting_nxt = `RXEQ_EQ_MIN;
      best_nxt    = `RXEQ_EQ_MIN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= rxeq_pkg::ADAPT_IDLE;
      timer_r   <= 24'h000000;
      dwell_r   <= 8'h00;
      setting_r <= `RXEQ_EQ_MIN;
      best_r    <= `RXEQ_EQ_MIN;
    end else begin
      state_r   <= state_nxt;
      timer_r   <= timer_nxt;
      dwell_r   <= dwell_nxt;
      setting_r <= setting_nxt;
      best_r    <= best_nxt;
    end
  end

  // trained stays set until the link leaves fixed-rate mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trainActive_r <= 1'b0;
      rate_r        <= 3'h0;
      trained_r     <= 1'b0;
    end else begin
      trainActive_r <= trainActive;
      rate_r        <= dataRate;
      trained_r     <= isFrl && (trained_r || trainRise);
    end
  end

  // ----------------------------------------------------------------------------
  // per-lane setting selection
  // ----------------------------------------------------------------------------
  logic [3:0] regEq [4];
  logic [3:0] initEq_r [4];
  logic [3:0] laneEq_r [4];
  logic [3:0] reducedEq [4];
  logic [3:0] laneBypass_r;
  logic [3:0] laneOutEnable_r;
  logic [3:0] adaptedEq_r;
  logic       adaptDone_r;

  wire logic       strapFallback;
  wire logic       useAdapted;
  wire logic       holdOut;
  wire logic [3:0] lanesUsed;

  assign regEq[0] = regEqLane0;
  assign regEq[1] = regEqLane1;
  assign regEq[2] = regEqLane2;
  assign regEq[3] = regEqLane3;

  assign strapFallback = ltpTest && !trained_r; // (R16)
  assign useAdapted    = adaptOn && trained_r; // (R19)

  genvar gl;
  generate
    for (gl = 0; gl < `RXEQ_LANES; gl++) begin : g_lane
      wire logic [3:0] baseEq;
      wire logic [3:0] initNow;
      wire logic [3:0] legacyEq;
      wire logic [3:0] eqNxt;

      assign baseEq   = regMode ? regEq[gl] : strapEq; // (R4) (R11)
      assign initNow  = strapFallback ? strapEq :
                        useAdapted ? best_r : baseEq; // (R15) (R19)
      // clock lane in legacy modes runs at the lowest setting
      assign legacyEq = (gl == `RXEQ_CLK_LANE) ? `RXEQ_EQ_MIN : baseEq; // (R11)
      assign eqNxt    = isFrl ? reducedEq[gl] : legacyEq;

      rxeq_txffe_reduce u_reduce (
        .enable    (compatOn),
        .level     (txffeLevel),
        .initEq    (initEq_r[gl]),
        .reducedEq (reducedEq[gl])
      );

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          initEq_r[gl]     <= `RXEQ_EQ_MIN;
          laneEq_r[gl]     <= `RXEQ_EQ_MIN;
          laneBypass_r[gl] <= 1'b0;
        end else begin
          if (txffeLevel == `RXEQ_TXFFE0) initEq_r[gl] <= initNow; // (R10)
          laneEq_r[gl]     <= eqNxt;
          laneBypass_r[gl] <= bypassOn && (eqNxt == `RXEQ_EQ_BYPASS); // (R3)
        end
      end
    end
  endgenerate

  // three-lane fixed-rate links leave the clock lane unused
  assign lanesUsed = (isFrl && !frlFourLane) ? `RXEQ_LANES_THREE : `RXEQ_LANES_ALL;
  assign holdOut   = adaptOn && ((state_r != rxeq_pkg::ADAPT_DONE) || startAdapt) &&
                     (regMode ? outputHoldUntilAdapted : 1'b1); // (R12) (R13)

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      laneOutEnable_r <= `RXEQ_LANES_NONE;
      adaptedEq_r     <= `RXEQ_EQ_MIN;
      adaptDone_r     <= 1'b0;
    end else begin
      laneOutEnable_r <= holdOut ? `RXEQ_LANES_NONE : lanesUsed; // (R12)
      adaptedEq_r     <= best_r;
      adaptDone_r     <= (state_r == rxeq_pkg::ADAPT_DONE);
    end
  end

  assign laneEq0       = laneEq_r[0];
  assign laneEq1       = laneEq_r[1];
  assign laneEq2       = laneEq_r[2];
  assign laneEq3       = laneEq_r[3];
  assign laneBypass    = laneBypass_r;
  assign laneOutEnable = laneOutEnable_r;
  assign adaptedEq     = adaptedEq_r;
  assign adaptDone     = adaptDone_r;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  property p_bypassCause;
    @(posedge clk) disable iff (!resetn)
      (laneBypass_r != 4'h0) |-> $past(regMode) && $past(eqBypassEnable) && ($past(globalDcGain) == 2'h2);
  endproperty
  a_bypassCause: assert property (p_bypassCause) else $error("bypass without register enable"); // (R1)

  property p_strapNoBypass;
    @(posedge clk) disable iff (!resetn)
      !regMode |=> (laneBypass_r == 4'h0);
  endproperty
  a_strapNoBypass: assert property (p_strapNoBypass) else $error("bypass in strap mode"); // (R2)

  property p_bypassLane0;
    @(posedge clk) disable iff (!resetn)
      $past(bypassOn) |-> (laneBypass_r[0] == (laneEq_r[0] == 4'h0));
  endproperty
  a_bypassLane0: assert property (p_bypassLane0) else $error("lane 0 bypass mismatch"); // (R3)

  property p_legacyIdle;
    @(posedge clk) disable iff (!resetn)
      !isFrl |=> (state_r == rxeq_pkg::ADAPT_IDLE);
  endproperty
  a_legacyIdle: assert property (p_legacyIdle) else $error("adaptation outside fixed-rate mode"); // (R4)

  property p_regNeedsEnable;
    @(posedge clk) disable iff (!resetn)
      (regMode && !adaptEnable) |=> (state_r == rxeq_pkg::ADAPT_IDLE);
  endproperty
  a_regNeedsEnable: assert property (p_regNeedsEnable) else $error("adaptation without enable"); // (R5)

  property p_stepGate;
    @(posedge clk) disable iff (!resetn)
      ($past(state_r) == rxeq_pkg::ADAPT_SCAN && $changed(setting_r) && !$past(startAdapt)) |-> $past(stepOk);
  endproperty
  a_stepGate: assert property (p_stepGate) else $error("setting stepped outside level 0 patterns"); // (R8)

  property p_timeBound;
    @(posedge clk) disable iff (!resetn)
      (state_r == rxeq_pkg::ADAPT_SCAN) |-> (timer_r < 24'(ADAPT_DONE_CYCLES));
  endproperty
  a_timeBound: assert property (p_timeBound) else $error("adaptation overran its time"); // (R9)

  property p_holdLevel;
    @(posedge clk) disable iff (!resetn)
      (txffeLevel != 2'h0 && !startAdapt) |=> $stable(initEq_r[0]) && $stable(best_r);
  endproperty
  a_holdLevel: assert property (p_holdLevel) else $error("setting changed after level 0"); // (R10)

  property p_outputsHeld;
    @(posedge clk) disable iff (!resetn)
      holdOut |=> (laneOutEnable_r == 4'h0);
  endproperty
  a_outputsHeld: assert property (p_outputsHeld) else $error("lanes enabled before adaptation done"); // (R12)

  property p_sameLanes;
    @(posedge clk) disable iff (!resetn)
      (useAdapted && !strapFallback && txffeLevel == 2'h0) |=>
        (initEq_r[1] == initEq_r[0]) && (initEq_r[2] == initEq_r[0]);
  endproperty
  a_sameLanes: assert property (p_sameLanes) else $error("data lanes differ after adaptation"); // (R15)

  property p_reduceLevel1;
    @(posedge clk) disable iff (!resetn)
      (compatOn && txffeLevel == 2'h1 && initEq_r[0] >= 4'h8) |-> (reducedEq[0] == initEq_r[0] - 4'h4);
  endproperty
  a_reduceLevel1: assert property (p_reduceLevel1) else $error("level 1 reduction wrong"); // (R20)

endmodule

// >>> bench/rxeq_src_model.sv
// Upstream source model: snooped training state and the lane 0 over-equalization detector.
`timescale 1ns/1ps
module rxeq_src_model (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic       go,
  input  wire logic       toLegacy,
  input  wire logic [3:0] overAt,
  input  wire logic [2:0] rate,
  input  wire logic [1:0] ffe,
  // snooped link state
  output logic      [1:0] linkMode = 2'h0,
  output logic            trainActive = 1'b0,
  output logic      [1:0] txffeLevel = 2'h0,
  output logic      [3:0] patternNum = 4'h0,
  output logic      [2:0] dataRate = 3'h0,
  output logic            overEq
);
  int unsigned waitCnt = 0;
  int unsigned lockCnt = 0;
  // ---------------------------------------------------------------------------
  // training sequence
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    txffeLevel <= ffe;
    if (toLegacy) begin
      linkMode <= 2'h0;
      trainActive <= 1'b0;
      patternNum <= 4'h0;
    end else if (go) begin
      linkMode <= 2'h2;
      trainActive <= 1'b1;
      dataRate <= rate;
      waitCnt <= 0;
      lockCnt <= 0;
      patternNum <= 4'h0;
    end else if (trainActive) begin
      // gap with no adaptation pattern, so steps must pause
      if (waitCnt < 100) waitCnt <= waitCnt + 1;
      else patternNum <= 4'h5;
      if (patternNum == 4'h5 && txffeLevel == 2'h0) lockCnt <= lockCnt + 1;
    end
  end
  // mid-dwell edge: setting overAt is the first one seen as over-equalized
  assign overEq = (lockCnt >= overAt * 64 + 32);
endmodule

// >>> bench/rxeq_adapt_control_bench.sv
// Self-checking bench for the receiver equalizer adaptation control block.
`timescale 1ns/1ps
module rxeq_adapt_control_bench;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [1:0]  modeStrap = 2'h0;
  logic [1:0]  mapStrap = 2'h0;
  logic [3:0]  eqStrapPins = 4'h0;
  logic        limitedRedriver = 1'b0;
  logic        eqBypassEnable = 1'b0;
  logic [1:0]  globalDcGain = 2'h0;
  logic        adaptEnable = 1'b0;
  logic        holdBit = 1'b0, fourLane = 1'b1;
  logic [3:0]  reg0 = 4'h0, reg1 = 4'h0, reg2 = 4'h0, reg3 = 4'h0;
  logic        go = 1'b0, toLegacy = 1'b0;
  logic [3:0]  overAt = 4'h0;
  logic [2:0]  rate = 3'h0;
  logic [1:0]  ffe = 2'h0;
  wire  [1:0]  linkMode, txffeLevel;
  wire  [3:0]  patternNum, laneEq0, laneEq1, laneEq2, laneEq3, laneBypass, laneOutEnable, adaptedEq;
  wire  [2:0]  dataRate;
  wire         trainActive, overEq, adaptDone;
  int          miscompares = 0;
  int          comparisons = 0;
  int unsigned seedVal;
  logic [3:0]  best;
  rxeq_adapt_control #(.ADAPT_DONE_CYCLES(2000)) rxeq_adapt_control_i (
    .clk(clk), .resetn(resetn), .modeStrap(modeStrap), .eqMapSelectStrap(mapStrap), .eqStrapPins(eqStrapPins),
    .limitedRedriver(limitedRedriver), .eqBypassEnable(eqBypassEnable), .globalDcGain(globalDcGain),
    .adaptEnable(adaptEnable), .outputHoldUntilAdapted(holdBit), .regEqLane0(reg0), .regEqLane1(reg1),
    .regEqLane2(reg2), .regEqLane3(reg3), .linkMode(linkMode), .trainActive(trainActive),
    .txffeLevel(txffeLevel), .patternNum(patternNum), .dataRate(dataRate), .frlFourLane(fourLane),
    .dataLane0OverEq(overEq), .laneEq0(laneEq0), .laneEq1(laneEq1), .laneEq2(laneEq2), .laneEq3(laneEq3),
    .laneBypass(laneBypass), .laneOutEnable(laneOutEnable), .adaptDone(adaptDone), .adaptedEq(adaptedEq));
  rxeq_src_model rxeq_src_model_i (
    .clk(clk), .go(go), .toLegacy(toLegacy), .overAt(overAt), .rate(rate), .ffe(ffe), .linkMode(linkMode),
    .trainActive(trainActive), .txffeLevel(txffeLevel), .patternNum(patternNum), .dataRate(dataRate),
    .overEq(overEq));
  initial forever #25 clk = ~clk;
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [3:0] red(input logic [1:0] l, input logic [3:0] e);
    case (l)
      2'h1: red = (e < 4'h8) ? (e >> 1) : e - 4'h4;
      2'h2: red = (e < 4'h4) ? 4'h0 : (e < 4'h8) ? 4'h1 : e - 4'h6;
      2'h3: red = (e < 4'h8) ? 4'h0 : (e < 4'hC) ? 4'h1 : e - 4'hA;
      default: red = e;
    endcase
  endfunction
  function automatic logic byp(input logic [3:0] e);
    byp = eqBypassEnable && globalDcGain == 2'h2 && e == 4'h0;
  endfunction
  function automatic logic [3:0] pick();
    pick = ($urandom_range(1, 0) == 0) ? 4'h0 : 4'($urandom);
  endfunction
  task automatic rst(input logic [1:0] m, input logic [3:0] e);
    @(negedge clk);
    resetn = 1'b0;
    modeStrap = m;
    eqStrapPins = e;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic adapt(input logic [3:0] t, input logic [2:0] r);
    int n;
    logic held;
    held = 1'b1;
    overAt = t;
    rate = r;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (n > 4 && adaptDone === 1'b1) break;
      if (n > 4 && laneOutEnable !== 4'h0) held = 1'b0;
    end
    best = t - 4'h1;
    chk("outputs held", {3'h0, holdBit || modeStrap != 2'h2}, {3'h0, held});
    chk("adaptDone", 4'h1, {3'h0, adaptDone});
    @(negedge clk);
    chk("adaptedEq", best, adaptedEq);
    chk("laneEq0", best, laneEq0);
    chk("laneEq3", best, laneEq3);
    chk("laneOutEnable", fourLane ? 4'hF : 4'h7, laneOutEnable);
    for (int l = 1; l < 4; l++) begin
      ffe = 2'(l);
      repeat (4) @(negedge clk);
      chk("laneEq1 reduced", red(2'(l), best), laneEq1);
      chk("adaptDone held", 4'h1, {3'h0, adaptDone});
    end
    ffe = 2'h0;
    repeat (4) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    #(50 * 20000);
    miscompares++;
    print_verdict();
  end
  initial begin
    seedVal = $urandom(32'h1818);
    eqBypassEnable = 1'b1;
    globalDcGain = 2'h2;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        rst(2'h0, {(r == 1) ? 2'h2 : (r == 2) ? 2'h1 : 2'(r), 2'(c)});
        chk("strap laneEq0", 4'(r * 4 + c), laneEq0);
        chk("strap laneEq2", 4'(r * 4 + c), laneEq2);
        chk("strap laneBypass", 4'h0, laneBypass);
      end
    end
    $display("test strap decode done");
    rst(2'h2, 4'h0);
    for (int i = 0; i < 8; i++) begin
      eqBypassEnable = (i != 6);
      globalDcGain = 2'(i);
      reg0 = pick();
      reg1 = pick();
      reg2 = pick();
      reg3 = pick();
      repeat (4) @(negedge clk);
      chk("reg laneEq0", reg0, laneEq0);
      chk("reg laneEq2", reg2, laneEq2);
      chk("laneBypass", {byp(4'h0), byp(reg2), byp(reg1), byp(reg0)}, laneBypass);
    end
    $display("test register bypass done");
    eqBypassEnable = 1'b0;
    limitedRedriver = 1'b1;
    adaptEnable = 1'b1;
    holdBit = 1'b1;
    for (int k = 0; k < 3; k++) begin
      fourLane = (k != 1);
      holdBit = (k != 2);
      adapt((k == 0) ? 4'hD : 4'($urandom_range(14, 1)), 3'(k + 1));
    end
    limitedRedriver = 1'b0;
    ffe = 2'h2;
    repeat (4) @(negedge clk);
    chk("unreduced laneEq0", best, laneEq0);
    ffe = 2'h0;
    $display("test adaptation done");
    toLegacy = 1'b1;
    @(negedge clk);
    toLegacy = 1'b0;
    repeat (6) @(negedge clk);
    chk("fallback laneEq0", reg0, laneEq0);
    adaptEnable = 1'b0;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (200) @(negedge clk);
    chk("no adapt laneEq1", reg1, laneEq1);
    chk("no adapt adaptDone", 4'h0, {3'h0, adaptDone});
    $display("test fallback done");
    mapStrap = 2'h3;
    limitedRedriver = 1'b1;
    rst(2'h3, 4'h9);
    adapt(4'h6, 3'h4);
    $display("test strap adaptation done");
    print_verdict();
  end
endmodule
